// [hdl/rt_opt_pkg.sv]
// Constants and types for the global remote-terminal option register
package rt_opt_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [15:0] OPT_ADDR      = 16'h004d;
    localparam logic [15:0] OPT_RESET     = 16'h0000;
    localparam logic [15:0] OPT_WR_MASK   = 16'h001c;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 16;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int          RSVD_BIT      = 4;
    localparam int          GAP_SEL_BIT   = 3;
    localparam int          BUSY_EN_BIT   = 2;
    localparam int          WAS_BUSY_BIT  = 9;
    localparam int          GAP_BROADCAST_INDICATION_BIT = 13;
    localparam logic [15:0] WAS_BUSY_MASK = 16'h0200;
    localparam logic [15:0] ZERO_WORD     = 16'h0000;
    // --------------------------------------------------------------
    // Meaning of message word bit 13
    // --------------------------------------------------------------
    typedef enum logic {
        IND_GAP   = 1'b0,
        IND_BCAST = 1'b1
    } indication_t;
endpackage

// [hdl/opt_if.sv]
// Option settings passed from the register bank to the word formatter
`timescale 1ns/1ps
`default_nettype none
interface opt_if;
    rt_opt_pkg::indication_t gap_broadcast_select;
    logic                    busy_report_enable;
    modport owner (output gap_broadcast_select, output busy_report_enable);
    modport user  (input gap_broadcast_select, input busy_report_enable);
endinterface
`default_nettype wire

// [hdl/miw_format.sv]
// Message information word formatter, places gap or broadcast flag in bit 13
`timescale 1ns/1ps
`default_nettype none
module miw_format
    import rt_opt_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Options
    opt_if.user                    opt,
    // Raw word in
    input  wire logic              msg_valid,
    input  wire logic [DATA_W-1:0] msg_word,
    input  wire logic              msg_gap_error,
    input  wire logic              msg_broadcast,
    // Formatted word out
    output logic                   miw_valid,
    output logic [DATA_W-1:0]      miw_word
);
    logic              miw_valid_reg;
    logic              miw_valid_next;
    logic [DATA_W-1:0] miw_word_reg;
    logic [DATA_W-1:0] miw_word_next;

    // ----------------------------------------------------------------
    // Bit 13 selection
    // ----------------------------------------------------------------
    always_comb begin
        miw_valid_next = msg_valid;
        miw_word_next  = miw_word_reg;
        if (msg_valid) begin
            miw_word_next = msg_word;
            unique case (opt.gap_broadcast_select)
                IND_GAP:   miw_word_next[GAP_BROADCAST_INDICATION_BIT] = msg_gap_error;
                IND_BCAST: miw_word_next[GAP_BROADCAST_INDICATION_BIT] = msg_broadcast;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            miw_valid_reg <= 1'b0;
            miw_word_reg  <= ZERO_WORD;
        end else begin
            miw_valid_reg <= miw_valid_next;
            miw_word_reg  <= miw_word_next;
        end
    end

    assign miw_valid = miw_valid_reg;
    assign miw_word  = miw_word_reg;
endmodule
`default_nettype wire

// [hdl/rt_extended_option_register.sv]
// Global remote-terminal option register with interrupt log word builder
// Summary of operation
// - The option register sits at word address 0x004d with gap/broadcast select at bit 3 and busy reporting at bit 2.
// - With the select bit at 0, bit 13 of message information words carries the gap error flag.
// - With the select bit at 1, bit 13 of those words carries the broadcast flag instead.
// - With busy reporting on, an enabled event while busy sets was-busy bit 9 of the logged word.
// - With busy reporting on, an enabled event while not busy logs only the event flags with bit 9 clear.
// - With busy reporting off, bit 9 of every logged word is written as 0.
// - A log entry is written only when an enabled interrupt event occurs.
// - Busy status alone is never an event and never writes a log entry.
// - Busy reporting leaves the pending interrupt bits alone, whose bit 9 stays zero.
`timescale 1ns/1ps
`default_nettype none
module rt_extended_option_register
    import rt_opt_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Host register access
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   reg_ack,
    // Message information word path
    input  wire logic              msg_valid,
    input  wire logic [DATA_W-1:0] msg_word,
    input  wire logic              msg_gap_error,
    input  wire logic              msg_broadcast,
    output logic                   miw_valid,
    output logic [DATA_W-1:0]      miw_word,
    // Interrupt events
    input  wire logic              ev_valid,
    input  wire logic              ev_terminal,
    input  wire logic [DATA_W-1:0] ev_flags,
    input  wire logic [DATA_W-1:0] ev_enable,
    input  wire logic              rt_busy,
    // Interrupt log entry
    output logic                   log_wr,
    output logic                   log_terminal,
    output logic [DATA_W-1:0]      interrupt_identification_word,
    // Pending interrupt set pulses
    output logic [DATA_W-1:0]      pending_set
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic opt_hit(input logic [ADDR_W-1:0] addr);
        opt_hit = (addr == OPT_ADDR);
    endfunction

    // ----------------------------------------------------------------
    // Option register
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] opt_reg;
    logic [DATA_W-1:0] opt_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              ack_reg;
    logic              ack_next;

    always_comb begin
        opt_next   = opt_reg;
        rdata_next = ZERO_WORD;
        ack_next   = 1'b0;
        if (reg_wr && opt_hit(reg_addr)) begin
            opt_next = reg_wdata & OPT_WR_MASK;
        end
        if (reg_rd && opt_hit(reg_addr)) begin
            rdata_next = opt_reg & OPT_WR_MASK;
            ack_next   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            opt_reg   <= OPT_RESET;
            rdata_reg <= ZERO_WORD;
            ack_reg   <= 1'b0;
        end else begin
            opt_reg   <= opt_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_ack   = ack_reg;

    // ----------------------------------------------------------------
    // Option fan-out
    // ----------------------------------------------------------------
    opt_if opt_bus ();

    // Bit 4 is stored and read back but steers nothing
    assign opt_bus.gap_broadcast_select = indication_t'(opt_reg[GAP_SEL_BIT]);
    assign opt_bus.busy_report_enable   = opt_reg[BUSY_EN_BIT];

    // ----------------------------------------------------------------
    // Message information word formatting
    // ----------------------------------------------------------------
    miw_format u_miw_format (
        .clk           (clk),
        .rst           (rst),
        .opt           (opt_bus),
        .msg_valid     (msg_valid),
        .msg_word      (msg_word),
        .msg_gap_error (msg_gap_error),
        .msg_broadcast (msg_broadcast),
        .miw_valid     (miw_valid),
        .miw_word      (miw_word)
    );

    // ----------------------------------------------------------------
    // Interrupt log word
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] ev_active;
    logic              log_wr_reg;
    logic              log_wr_next;
    logic              log_term_reg;
    logic              log_term_next;
    logic [DATA_W-1:0] iiw_reg;
    logic [DATA_W-1:0] iiw_next;
    logic [DATA_W-1:0] pend_reg;
    logic [DATA_W-1:0] pend_next;

    // Bit 9 is never an event source
    assign ev_active = ev_flags & ev_enable & ~WAS_BUSY_MASK;

    always_comb begin
        log_wr_next   = 1'b0;
        log_term_next = log_term_reg;
        iiw_next      = iiw_reg;
        pend_next     = ZERO_WORD;
        if (ev_valid && (ev_active != ZERO_WORD)) begin
            log_wr_next   = 1'b1;
            log_term_next = ev_terminal;
            iiw_next      = ev_active;
            if (opt_bus.busy_report_enable && rt_busy) begin
                iiw_next[WAS_BUSY_BIT] = 1'b1;
            end
            pend_next = ev_active;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            log_wr_reg   <= 1'b0;
            log_term_reg <= 1'b0;
            iiw_reg      <= ZERO_WORD;
            pend_reg     <= ZERO_WORD;
        end else begin
            log_wr_reg   <= log_wr_next;
            log_term_reg <= log_term_next;
            iiw_reg      <= iiw_next;
            pend_reg     <= pend_next;
        end
    end

    assign log_wr                        = log_wr_reg;
    assign log_terminal                  = log_term_reg;
    assign interrupt_identification_word = iiw_reg;
    assign pending_set                   = pend_reg;
endmodule
`default_nettype wire

// [test/rt_host_model.sv]
// Host processor model issuing single-word register accesses
`timescale 1ns/1ps
`default_nettype none
module rt_host_model
    import rt_opt_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register access
    output logic [ADDR_W-1:0]      reg_addr,
    output logic                   reg_wr,
    output logic [DATA_W-1:0]      reg_wdata,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              reg_ack
);
    initial begin
        reg_addr  = 16'hffff;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // One write or read strobe, answer taken one cycle later
    task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] q, output logic ack);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d & ~(16'h0001 << RSVD_BIT);
        reg_wr    = w;
        reg_rd    = !w;
        @(negedge clk);
        q         = reg_rdata;
        ack       = reg_ack;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~reg_wdata;
    endtask
endmodule
`default_nettype wire

// [test/rt_extended_option_register_properties.sv]
// Port checker for the global remote-terminal option register
`timescale 1ns/1ps
`default_nettype none
module rt_opt_checker
    import rt_opt_pkg::*;
(
    // Clock, reset and host access
    input wire logic clk, rst, reg_wr, reg_rd, reg_ack,
    input wire logic [15:0] reg_addr, reg_wdata, reg_rdata,
    // Message path
    input wire logic msg_valid, msg_gap_error, msg_broadcast, miw_valid,
    input wire logic [15:0] msg_word, miw_word,
    // Event path
    input wire logic ev_valid, rt_busy, log_wr,
    input wire logic [15:0] ev_flags, ev_enable, interrupt_identification_word, pending_set
);
    logic [15:0] shadow;
    always_ff @(posedge clk) begin
        if (rst) shadow <= OPT_RESET;
        else if (reg_wr && reg_addr == OPT_ADDR) shadow <= reg_wdata & OPT_WR_MASK;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_ack: assert property (reg_rd && reg_addr == OPT_ADDR |=> reg_ack)
        else $error("read of option register not answered");
    a_other_addr: assert property (reg_rd && reg_addr != OPT_ADDR |=> !reg_ack)
        else $error("read of other address answered");
    a_read_value: assert property (reg_ack |-> reg_rdata == $past(shadow))
        else $error("option read data wrong");
    a_miw_timing: assert property (msg_valid |=> miw_valid)
        else $error("formatted word late");
    a_miw_bit13: assert property (miw_valid |-> miw_word[13] == ($past(shadow[GAP_SEL_BIT]) ?
        $past(msg_broadcast) : $past(msg_gap_error)) && (miw_word & ~16'h2000) == ($past(msg_word) & ~16'h2000))
        else $error("formatted word bit 13 wrong");
    a_log_event: assert property (log_wr |-> $past(ev_valid && |(ev_flags & ev_enable & ~WAS_BUSY_MASK)))
        else $error("log written without enabled event");
    a_busy_alone: assert property (ev_valid && rt_busy && !(|(ev_flags & ev_enable & ~WAS_BUSY_MASK)) |=> !log_wr)
        else $error("busy alone wrote log");
    a_was_busy: assert property (log_wr |-> interrupt_identification_word[WAS_BUSY_BIT] ==
        $past(shadow[BUSY_EN_BIT] && rt_busy))
        else $error("was-busy flag wrong");
    a_pending: assert property (log_wr |-> pending_set == $past(ev_flags & ev_enable & ~WAS_BUSY_MASK))
        else $error("pending bits wrong");
    a_rsvd_zero: assert property (reg_rdata[15:5] == 11'h000)
        else $error("unused option bits read nonzero");
    a_pend_bit9: assert property (!pending_set[WAS_BUSY_BIT])
        else $error("pending bit 9 set");
    a_pend_only_log: assert property (pending_set != ZERO_WORD |-> log_wr)
        else $error("pending pulse without log entry");
endmodule
bind rt_extended_option_register rt_opt_checker i_chk (.clk, .rst, .reg_wr, .reg_rd, .reg_ack, .reg_addr,
    .reg_wdata, .reg_rdata, .msg_valid, .msg_gap_error, .msg_broadcast, .miw_valid, .msg_word, .miw_word,
    .ev_valid, .rt_busy, .log_wr, .ev_flags, .ev_enable, .interrupt_identification_word, .pending_set);
`default_nettype wire

// [test/tb_rt_extended_option_register.sv]
// Self-checking bench for the global remote-terminal option register
`timescale 1ns/1ps
`default_nettype none
module tb_rt_extended_option_register;
    import rt_opt_pkg::*;
    logic clk, rst, reg_wr, reg_rd, reg_ack, msg_valid, msg_gap_error, msg_broadcast, miw_valid, ack;
    logic ev_valid, ev_terminal, rt_busy, log_wr, log_terminal;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, msg_word, miw_word, ev_flags, ev_enable, pending_set, q;
    logic [15:0] interrupt_identification_word;
    int          mismatches = 0, n_tests = 0, cycles = 0;
    rt_extended_option_register i_dut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_ack, .msg_valid, .msg_word, .msg_gap_error, .msg_broadcast, .miw_valid, .miw_word, .ev_valid,
        .ev_terminal, .ev_flags, .ev_enable, .rt_busy, .log_wr, .log_terminal, .interrupt_identification_word,
        .pending_set);
    rt_host_model i_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_ack);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_regs();
        i_host.access(1'b0, OPT_ADDR, 16'h0000, q, ack);
        check("reset value", q, OPT_RESET);
        i_host.access(1'b1, OPT_ADDR, 16'hffff, q, ack);
        i_host.access(1'b0, OPT_ADDR, 16'h0000, q, ack);
        check("readback", q, 16'h000c);
        check("read ack", {15'h0000, ack}, 16'h0001);
        i_host.access(1'b0, OPT_ADDR + 16'h0001, 16'h0000, q, ack);
        check("unmapped ack", {15'h0000, ack}, 16'h0000);
        check("unmapped data", q, ZERO_WORD);
        $display("test_regs done");
    endtask
    task automatic test_miw();
        for (int s = 0; s < 2; s++) begin
            i_host.access(1'b1, OPT_ADDR, {12'h000, s[0], 3'h0}, q, ack);
            @(negedge clk);
            msg_valid = 1'b1;
            @(negedge clk);
            msg_valid = 1'b0;
            check("miw valid", {15'h0000, miw_valid}, 16'h0001);
            check("miw word", miw_word, s ? 16'h5555 : 16'h7555);
        end
        $display("test_miw done");
    endtask
    task automatic test_busy();
        for (int k = 0; k < 4; k++) begin
            i_host.access(1'b1, OPT_ADDR, {13'h0000, k[1], 2'h0}, q, ack);
            @(negedge clk);
            ev_valid = 1'b1;
            ev_enable = 16'hffff;
            ev_terminal = k[1];
            rt_busy = k[0];
            @(negedge clk);
            ev_valid = 1'b0;
            check("log entry", {15'h0000, log_wr}, 16'h0001);
            check("log terminal", {15'h0000, log_terminal}, {15'h0000, k[1]});
            check("id word", interrupt_identification_word, {6'h00, k[1] & k[0], 9'h004});
            check("pending", pending_set, 16'h0004);
        end
        @(negedge clk);
        ev_valid = 1'b1;
        ev_enable = 16'h0200;
        @(negedge clk);
        ev_valid = 1'b0;
        check("no entry", {15'h0000, log_wr}, 16'h0000);
        $display("test_busy done");
    endtask
    task automatic test_reset();
        i_host.access(1'b1, OPT_ADDR, 16'h000c, q, ack);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("log after reset", {15'h0000, log_wr}, 16'h0000);
        i_host.access(1'b0, OPT_ADDR, 16'h0000, q, ack);
        check("value after reset", q, OPT_RESET);
        $display("test_reset done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {msg_valid, msg_gap_error, msg_broadcast, ev_valid, ev_terminal, rt_busy} = 6'b010_010;
        msg_word = 16'h5555;
        ev_flags = 16'h0204;
        ev_enable = 16'h0000;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        test_regs();
        test_miw();
        test_busy();
        test_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
